/* logic/rtc_gate_defines.vh */
// address map, field positions, reset values and codes for the rtc register gating block
`ifndef RTC_GATE_DEFINES_VH
`define RTC_GATE_DEFINES_VH

// sfr byte addresses (20-bit cpu space)
`define ADDR_PER_A 20'hF_00F0
`define ADDR_PER_B 20'hF_007A
`define ADDR_SUPPLY_MODE 20'hF_00F3
// gated clock register window: local indices behind the rtc register base
`define ADDR_RTC_BASE 20'hF_FF90
`define RTC_REG_COUNT 16
`define RTC_IDX_W 4
`define RTC_IDX_CORR 4'hF

// field positions
`define BIT_CLK_REG_EN 7
`define BIT_FREQ_MEAS_EN 6
`define BIT_LOW_POWER 7
`define BIT_SRC_SEL 4

// reset values and writable masks
`define RST_BYTE 8'h00
`define MASK_PER_A 8'hFD
`define MASK_PER_B 8'hF9
`define MASK_SUPPLY_MODE 8'h90

// power modes
`define PM_RUN 2'h0
`define PM_HALT 2'h1
`define PM_STOP 2'h2

`endif

/* logic/rtc_reg_bank.v */
// retained clock-register bank: no reset, writes only through the gated strobe
`timescale 1ns/1ns
`include "rtc_gate_defines.vh"

module rtc_reg_bank #(
    parameter DEPTH = `RTC_REG_COUNT,
    parameter AW = `RTC_IDX_W
) (
    input wire clock,
    input wire wr_en,
    input wire [AW-1:0] wr_idx,
    input wire [7:0] wr_data,
    input wire [AW-1:0] rd_idx,
    output reg [7:0] rd_data
);
    reg [7:0] mem [0:DEPTH-1];

    // no reset port at all: contents survive every reset source
    always @(posedge clock)
    begin
        if (wr_en)
        begin
            mem[wr_idx] <= wr_data;
        end
        rd_data <= mem[rd_idx];
    end
endmodule

/* logic/rtc_register_clock_gating.v */
// access and clock gating for the rtc register set: enable registers and supply mode
// Functional notes
// - calendar, count and alarm registers keep their contents through any reset.
// - with clock register enable low, writes to clock registers are ignored.
// - with enable low, reads return last enabled values; supply mode register exempt.
// - rtc counting keeps running regardless of the clock register enable.
// - correction register accessible when clock enable or frequency measure enable is set.
// - frequency measure enable low holds measurement circuit reset, blocks its writes.
// - reset clears both enable registers and the supply mode register to zero.
// - low power bit stops subclock to unrelated peripherals in stop or sub halt.
// - supply mode register takes byte writes only; enable registers bit or byte.
// - source select bit picks subclock at 0, low speed oscillator at 1.
// - with low speed oscillator only constant period interrupt runs.
`timescale 1ns/1ns
`include "rtc_gate_defines.vh"

module rtc_register_clock_gating #(
    parameter AW = 20
) (
    input wire clock,
    input wire rst,
    input wire [AW-1:0] addr,
    input wire wr_req,
    input wire rd_req,
    input wire bit_op,
    input wire [2:0] bit_pos,
    input wire [7:0] wr_data,
    input wire [1:0] power_mode,
    input wire cpu_on_subclock,
    input wire freq_meas_wr_req,
    output reg [7:0] rd_data,
    output reg rd_valid,
    output reg [7:0] peripheral_enable_a,
    output reg [7:0] peripheral_enable_b,
    output reg low_power_subclock_gate,
    output reg rtc_clock_source_select,
    output reg rtc_counting_enable,
    output reg calendar_enable,
    output reg const_period_enable,
    output reg freq_meas_reset,
    output reg freq_meas_wr_en,
    output reg subclock_to_misc_periph,
    output reg subclock_to_rtc_group
);
    // -------------------------------------------------------------------
    // decode helpers
    // -------------------------------------------------------------------
    function is_rtc_addr;
        input [AW-1:0] a;
        begin
            is_rtc_addr = (a >= `ADDR_RTC_BASE) &&
                          (a < `ADDR_RTC_BASE + `RTC_REG_COUNT);
        end
    endfunction

    // merge the selected lanes of a write into an old value, masking reserved bits
    function [7:0] merge;
        input [7:0] old;
        input [7:0] d;
        input [7:0] sel;
        input [7:0] mask;
        begin
            merge = ((old & ~sel) | (d & sel)) & mask;
        end
    endfunction

    // exact byte address match, shared by the write and read decoders
    function addr_match;
        input [AW-1:0] a;
        input [AW-1:0] target;
        begin
            addr_match = (a == target);
        end
    endfunction

    // stop, or halt while the cpu runs from the subclock: the only states in
    // which the low power bit takes the subclock away
    function low_power_state;
        input [1:0] pm;
        input on_sub;
        begin
            low_power_state = (pm == `PM_STOP) || ((pm == `PM_HALT) && on_sub);
        end
    endfunction

    reg [7:0] supply_mode_r;
    reg [7:0] per_a_nxt;
    reg [7:0] per_b_nxt;
    reg [7:0] supply_mode_nxt;
    wire [`RTC_IDX_W-1:0] rtc_idx;
    wire sel_rtc;
    wire hit_per_a;
    wire hit_per_b;
    wire hit_supply;
    wire clk_en;
    wire fm_en;
    wire corr_ok;
    wire [7:0] bit_sel;
    wire [7:0] bit_val;
    wire [3:0] rd_src;
    reg bank_wr;
    wire [7:0] bank_q;
    reg rd_rtc_r;
    reg [7:0] rd_mux_r;
    reg cal_en_nxt;
    reg fm_reset_nxt;
    reg fm_wr_en_nxt;
    reg misc_clk_nxt;

    // one-hot read source codes; any other pattern reads zero
    localparam [3:0] RD_SRC_PER_A = 4'h1;
    localparam [3:0] RD_SRC_PER_B = 4'h2;
    localparam [3:0] RD_SRC_SUPPLY = 4'h4;
    localparam [3:0] RD_SRC_BANK = 4'h8;

    // -------------------------------------------------------------------
    // address decode
    // -------------------------------------------------------------------
    assign rtc_idx = addr[`RTC_IDX_W-1:0];
    assign sel_rtc = is_rtc_addr(addr);
    assign hit_per_a = addr_match(addr, `ADDR_PER_A);
    assign hit_per_b = addr_match(addr, `ADDR_PER_B);
    assign hit_supply = addr_match(addr, `ADDR_SUPPLY_MODE);
    // the windows never overlap, so at most one bit of this code is set
    assign rd_src = {sel_rtc, hit_supply, hit_per_b, hit_per_a};
    assign clk_en = peripheral_enable_a[`BIT_CLK_REG_EN];
    assign fm_en = peripheral_enable_b[`BIT_FREQ_MEAS_EN];
    assign corr_ok = clk_en | fm_en;

    // -------------------------------------------------------------------
    // write lane selects
    // -------------------------------------------------------------------
    // a bit operation touches one lane and takes its value from wr_data[0]
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_lane
            assign bit_sel[gi] = !bit_op || (bit_pos == gi);
            assign bit_val[gi] = bit_op ? wr_data[0] : wr_data[gi];
        end
    endgenerate

    // -------------------------------------------------------------------
    // write gating for the retained bank
    // -------------------------------------------------------------------
    // only the strobe is suppressed; the read path never looks at the enables,
    // so a gated write leaves no trace and a gated read still answers
    always @*
    begin
        bank_wr = 1'b0;
        if (wr_req && sel_rtc)
        begin
            // correction index also opens with the measurement enable
            if (rtc_idx == `RTC_IDX_CORR)
                bank_wr = corr_ok;
            else
                bank_wr = clk_en;
        end
    end

    // -------------------------------------------------------------------
    // retained clock registers
    // -------------------------------------------------------------------
    // contents are read back even while gated, so values from the enabled period show
    rtc_reg_bank #(
        .DEPTH(`RTC_REG_COUNT),
        .AW(`RTC_IDX_W)
    ) u_bank (
        .clock(clock),
        .wr_en(bank_wr),
        .wr_idx(rtc_idx),
        .wr_data(wr_data),
        .rd_idx(rtc_idx),
        .rd_data(bank_q)
    );

    // -------------------------------------------------------------------
    // enable and supply mode registers
    // -------------------------------------------------------------------
    // enable register writes are never gated themselves, so software can always
    // reopen access; reserved lanes are masked and read back as zero
    always @*
    begin
        per_a_nxt = peripheral_enable_a;
        per_b_nxt = peripheral_enable_b;
        supply_mode_nxt = supply_mode_r;
        if (wr_req && hit_per_a)
            per_a_nxt = merge(peripheral_enable_a, bit_val, bit_sel, `MASK_PER_A);
        if (wr_req && hit_per_b)
            per_b_nxt = merge(peripheral_enable_b, bit_val, bit_sel, `MASK_PER_B);
        // bit operations on the supply mode register are dropped; not gated by enable
        if (wr_req && !bit_op && hit_supply)
            supply_mode_nxt = wr_data & `MASK_SUPPLY_MODE;
    end

    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            peripheral_enable_a <= `RST_BYTE;
            peripheral_enable_b <= `RST_BYTE;
        end
        else
        begin
            peripheral_enable_a <= per_a_nxt;
            peripheral_enable_b <= per_b_nxt;
        end
    end

    always @(posedge clock or posedge rst)
    begin
        if (rst)
            supply_mode_r <= `RST_BYTE;
        else
            supply_mode_r <= supply_mode_nxt;
    end

    // -------------------------------------------------------------------
    // read path: rd_valid after one cycle, rd_data after two, no side effects
    // -------------------------------------------------------------------
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rd_valid <= 1'b0;
            rd_rtc_r <= 1'b0;
            rd_mux_r <= `RST_BYTE;
        end
        else
        begin
            rd_valid <= rd_req; // every read completes regardless of enables
            rd_rtc_r <= rd_req && sel_rtc;
            // the bank answers through its own flop, so its code reads zero here
            case (rd_src)
                RD_SRC_PER_A: rd_mux_r <= peripheral_enable_a;
                RD_SRC_PER_B: rd_mux_r <= peripheral_enable_b;
                RD_SRC_SUPPLY: rd_mux_r <= supply_mode_r;
                RD_SRC_BANK: rd_mux_r <= `RST_BYTE;
                default: rd_mux_r <= `RST_BYTE;
            endcase
        end
    end

    // bank data arrives in the same cycle as rd_valid; register it once more so the
    // output stays a flip-flop, trading one extra cycle of latency
    always @(posedge clock or posedge rst)
    begin
        if (rst)
            rd_data <= `RST_BYTE;
        else if (rd_valid)
            rd_data <= rd_rtc_r ? bank_q : rd_mux_r;
    end

    // -------------------------------------------------------------------
    // next values of the mode outputs
    // -------------------------------------------------------------------
    always @*
    begin
        // low speed source: calendar and 1 hz unusable, constant period only
        cal_en_nxt = ~supply_mode_nxt[`BIT_SRC_SEL];
        // measurement circuit held in reset and writes blocked
        fm_reset_nxt = ~per_b_nxt[`BIT_FREQ_MEAS_EN];
        fm_wr_en_nxt = freq_meas_wr_req & per_b_nxt[`BIT_FREQ_MEAS_EN];
        // gate unrelated peripherals only in the two low power states
        misc_clk_nxt = ~(supply_mode_nxt[`BIT_LOW_POWER] &&
                         low_power_state(power_mode, cpu_on_subclock));
    end

    // -------------------------------------------------------------------
    // clock gating and mode outputs
    // -------------------------------------------------------------------
    // built from the next register values, so each port follows its register in
    // the same edge while still coming straight from a flop
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            low_power_subclock_gate <= 1'b0;
            rtc_clock_source_select <= 1'b0;
            rtc_counting_enable <= 1'b1;
            calendar_enable <= 1'b1;
            const_period_enable <= 1'b1;
            freq_meas_reset <= 1'b1;
            freq_meas_wr_en <= 1'b0;
            subclock_to_misc_periph <= 1'b1;
            subclock_to_rtc_group <= 1'b1;
        end
        else
        begin
            low_power_subclock_gate <= supply_mode_nxt[`BIT_LOW_POWER];
            rtc_clock_source_select <= supply_mode_nxt[`BIT_SRC_SEL];
            // counting never depends on the register enable bits
            rtc_counting_enable <= 1'b1;
            calendar_enable <= cal_en_nxt;
            const_period_enable <= 1'b1;
            freq_meas_reset <= fm_reset_nxt;
            freq_meas_wr_en <= fm_wr_en_nxt;
            subclock_to_misc_periph <= misc_clk_nxt;
            subclock_to_rtc_group <= 1'b1;
        end
    end
endmodule

/* tb/rtc_gate_chk.sv */
// concurrent checks on the ports of the rtc register gating block
`timescale 1ns/1ns
`include "rtc_gate_defines.vh"
module rtc_gate_chk #(
    parameter AW = 20
) (
    input logic clock,
    input logic rst,
    input logic [AW-1:0] addr,
    input logic wr_req,
    input logic rd_req,
    input logic bit_op,
    input logic [1:0] power_mode,
    input logic cpu_on_subclock,
    input logic freq_meas_wr_req,
    input logic rd_valid,
    input logic [7:0] peripheral_enable_a,
    input logic [7:0] peripheral_enable_b,
    input logic low_power_subclock_gate,
    input logic rtc_clock_source_select,
    input logic rtc_counting_enable,
    input logic calendar_enable,
    input logic freq_meas_reset,
    input logic freq_meas_wr_en,
    input logic subclock_to_misc_periph,
    input logic const_period_enable,
    input logic subclock_to_rtc_group
);
// ----------------------------------------
// properties
// ----------------------------------------
default clocking @(posedge clock); endclocking
default disable iff (rst);
AST_RD_PULSE: assert property (rd_valid == $past(rd_req))
    else $error("read answer late");
AST_COUNT_RUNS: assert property (rtc_counting_enable)
    else $error("counting stopped");
AST_CAL_SRC: assert property (calendar_enable == !rtc_clock_source_select)
    else $error("calendar enable wrong");
AST_CONST_PERIOD: assert property (const_period_enable)
    else $error("constant period stopped");
AST_RTC_GROUP: assert property (subclock_to_rtc_group)
    else $error("rtc group subclock stopped");
AST_FM_RESET: assert property (freq_meas_reset == !peripheral_enable_b[`BIT_FREQ_MEAS_EN])
    else $error("measure reset wrong");
AST_FM_BLOCK: assert property (freq_meas_wr_en |-> $past(freq_meas_wr_req))
    else $error("measure write without request");
AST_FM_PASS: assert property (freq_meas_wr_req && peripheral_enable_b[6] |=> freq_meas_wr_en)
    else $error("measure write lost");
// only judged once the mode inputs have settled, so either a flop or a gate passes
AST_MISC_GATE: assert property ($stable(power_mode) && $stable(cpu_on_subclock)
    && $stable(low_power_subclock_gate) |-> subclock_to_misc_periph == !(low_power_subclock_gate
    && (power_mode == `PM_STOP || (power_mode == `PM_HALT && cpu_on_subclock))))
    else $error("misc subclock gate wrong");
AST_SUPPLY_BYTE: assert property (wr_req && bit_op && addr == `ADDR_SUPPLY_MODE
    |=> $stable(low_power_subclock_gate) && $stable(rtc_clock_source_select))
    else $error("bit write reached supply mode");
AST_PEA_SRC: assert property ($changed(peripheral_enable_a)
    |-> $past(wr_req) && $past(addr) == `ADDR_PER_A)
    else $error("enable a changed without write");
endmodule
bind rtc_register_clock_gating rtc_gate_chk #(.AW(AW)) chk (
    .clock(clock), .rst(rst), .addr(addr), .wr_req(wr_req), .rd_req(rd_req),
    .bit_op(bit_op), .power_mode(power_mode), .cpu_on_subclock(cpu_on_subclock),
    .freq_meas_wr_req(freq_meas_wr_req), .rd_valid(rd_valid),
    .peripheral_enable_a(peripheral_enable_a), .peripheral_enable_b(peripheral_enable_b),
    .low_power_subclock_gate(low_power_subclock_gate),
    .rtc_clock_source_select(rtc_clock_source_select),
    .rtc_counting_enable(rtc_counting_enable), .calendar_enable(calendar_enable),
    .freq_meas_reset(freq_meas_reset), .freq_meas_wr_en(freq_meas_wr_en),
    .subclock_to_misc_periph(subclock_to_misc_periph),
    .const_period_enable(const_period_enable),
    .subclock_to_rtc_group(subclock_to_rtc_group));

/* tb/tb_top.sv */
// self-checking bench for the rtc register gating block
`timescale 1ns/1ns
`include "rtc_gate_defines.vh"
module tb_top;
logic clock, rst, wr_req, rd_req, bit_op, cpu_on_subclock, freq_meas_wr_req, rd_valid;
logic low_power_subclock_gate, rtc_clock_source_select, rtc_counting_enable, calendar_enable;
logic const_period_enable, freq_meas_reset, freq_meas_wr_en, subclock_to_misc_periph;
logic subclock_to_rtc_group;
logic [19:0] addr;
logic [2:0] bit_pos;
logic [1:0] power_mode;
logic [7:0] wr_data, rd_data, peripheral_enable_a, peripheral_enable_b;
int errors = 0, samples_checked = 0, cycles = 0;
rtc_register_clock_gating DUT (
    .clock(clock), .rst(rst), .addr(addr), .wr_req(wr_req), .rd_req(rd_req),
    .bit_op(bit_op), .bit_pos(bit_pos), .wr_data(wr_data), .power_mode(power_mode),
    .cpu_on_subclock(cpu_on_subclock), .freq_meas_wr_req(freq_meas_wr_req),
    .rd_data(rd_data), .rd_valid(rd_valid), .peripheral_enable_a(peripheral_enable_a),
    .peripheral_enable_b(peripheral_enable_b),
    .low_power_subclock_gate(low_power_subclock_gate),
    .rtc_clock_source_select(rtc_clock_source_select),
    .rtc_counting_enable(rtc_counting_enable), .calendar_enable(calendar_enable),
    .const_period_enable(const_period_enable), .freq_meas_reset(freq_meas_reset),
    .freq_meas_wr_en(freq_meas_wr_en), .subclock_to_misc_periph(subclock_to_misc_periph),
    .subclock_to_rtc_group(subclock_to_rtc_group));
// ----------------------------------------
// bus and check helpers
// ----------------------------------------
task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
    samples_checked++;
    if (seen !== exp)
    begin
        errors++;
        $display("Error %s expected %h seen %h", name, exp, seen);
    end
endtask
task automatic wr(input logic [19:0] a, input logic [7:0] d, input logic b, input logic [2:0] p);
    @(posedge clock);
    addr <= a;
    wr_data <= d;
    bit_op <= b;
    bit_pos <= p;
    wr_req <= 1'b1;
    @(posedge clock);
    wr_req <= 1'b0;
    #1;
endtask
task automatic rdc(input logic [19:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr <= a;
    rd_req <= 1'b1;
    @(posedge clock);
    rd_req <= 1'b0;
    #1;
    chk("rd_valid", 8'h01, {7'h00, rd_valid});
    @(posedge clock);
    #1;
    chk("rd_data", exp, rd_data);
endtask
task automatic fm_pulse(input logic exp);
    @(posedge clock);
    freq_meas_wr_req <= 1'b1;
    @(posedge clock);
    freq_meas_wr_req <= 1'b0;
    #1;
    chk("fm_wr_en", {7'h00, exp}, {7'h00, freq_meas_wr_en});
endtask
task automatic test_done;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
endtask
// ----------------------------------------
// scenarios
// ----------------------------------------
task automatic t_gate;
    wr(`ADDR_PER_A, 8'h80, 1'b0, 3'h0);
    wr(`ADDR_RTC_BASE + 20'h1, 8'hA5, 1'b0, 3'h0);
    rdc(`ADDR_RTC_BASE + 20'h1, 8'hA5);
    wr(`ADDR_PER_A, 8'h00, 1'b1, 3'h7);
    chk("pe_a", 8'h00, peripheral_enable_a);
    wr(`ADDR_RTC_BASE + 20'h1, 8'h3C, 1'b0, 3'h0);
    rdc(`ADDR_RTC_BASE + 20'h1, 8'hA5);
    chk("count_en", 8'h01, {7'h00, rtc_counting_enable});
endtask
task automatic t_corr;
    wr(`ADDR_PER_B, 8'h40, 1'b0, 3'h0);
    chk("fm_reset", 8'h00, {7'h00, freq_meas_reset});
    wr(`ADDR_RTC_BASE + 20'hF, 8'h77, 1'b0, 3'h0);
    rdc(`ADDR_RTC_BASE + 20'hF, 8'h77);
    fm_pulse(1'b1);
    wr(`ADDR_PER_B, 8'h00, 1'b0, 3'h0);
    chk("fm_reset", 8'h01, {7'h00, freq_meas_reset});
    wr(`ADDR_RTC_BASE + 20'hF, 8'h11, 1'b0, 3'h0);
    rdc(`ADDR_RTC_BASE + 20'hF, 8'h77);
    fm_pulse(1'b0);
endtask
task automatic t_supply;
    logic [3:0] row [4] = '{4'b0001, 4'b0101, 4'b0110, 4'b1000};
    wr(`ADDR_SUPPLY_MODE, 8'h90, 1'b0, 3'h0);
    chk("cal_en", 8'h00, {7'h00, calendar_enable});
    chk("src_sel", 8'h01, {7'h00, rtc_clock_source_select});
    chk("const_prd", 8'h01, {7'h00, const_period_enable});
    rdc(`ADDR_SUPPLY_MODE, 8'h90);
    wr(`ADDR_SUPPLY_MODE, 8'h00, 1'b1, 3'h7);
    chk("low_power", 8'h01, {7'h00, low_power_subclock_gate});
    foreach (row[i])
    begin
        @(posedge clock);
        power_mode <= row[i][3:2];
        cpu_on_subclock <= row[i][1];
        repeat (2) @(posedge clock);
        #1;
        chk("misc_clk", {7'h00, row[i][0]}, {7'h00, subclock_to_misc_periph});
    end
    chk("rtc_clk", 8'h01, {7'h00, subclock_to_rtc_group});
    wr(`ADDR_SUPPLY_MODE, 8'h00, 1'b0, 3'h0);
    chk("cal_en", 8'h01, {7'h00, calendar_enable});
endtask
task automatic t_reset;
    wr(`ADDR_PER_A, 8'h80, 1'b0, 3'h0);
    wr(`ADDR_PER_B, 8'h40, 1'b0, 3'h0);
    wr(`ADDR_RTC_BASE + 20'h2, 8'h5A, 1'b0, 3'h0);
    wr(`ADDR_SUPPLY_MODE, 8'h90, 1'b0, 3'h0);
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    #1;
    chk("regs", 8'h00, peripheral_enable_a | peripheral_enable_b);
    chk("supply", 8'h00, {6'h00, low_power_subclock_gate, rtc_clock_source_select});
    rdc(`ADDR_SUPPLY_MODE, 8'h00);
    wr(`ADDR_PER_A, 8'h80, 1'b0, 3'h0);
    rdc(`ADDR_RTC_BASE + 20'h2, 8'h5A);
    rdc(20'hF_0000, 8'h00);
endtask
// ----------------------------------------
// clock, reset, sequence and hang limit
// ----------------------------------------
initial
begin
    clock = 1'b0;
    forever #50 clock = ~clock;
end
always @(posedge clock)
begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
        errors++;
        test_done;
    end
end
initial
begin
    rst = 1'b1;
    {wr_req, rd_req, bit_op, cpu_on_subclock, freq_meas_wr_req} = 5'h00;
    {addr, bit_pos, power_mode, wr_data} = 33'h0_0000_0000;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    t_gate;
    t_corr;
    t_supply;
    t_reset;
    test_done;
end
endmodule
